// ### hdl/board_ctl_host.v
/*
  Host-side sequencer for the acquisition board's control word, channel
  select mask and pass/fail word. Software issues commands over a plain
  register port; the sequencer drives the board bus and runs the
  handshakes. Assumes a board bus that answers a read within the cycle in
  which bb_rd is high, in the same clock domain as the host logic.
*/
`timescale 1ns/1ps
`include "board_ctl_map.vh"

module board_ctl_host #(
  parameter RESET_WINDOW_CYC = `RESET_WINDOW_CYC,
  parameter DATA_PERIOD_CYC  = `DATA_PERIOD_CYC,
  parameter COEF_HOLD_CYC    = `COEF_HOLD_CYC
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire [3:0]  sw_addr,
  input  wire [15:0] sw_wdata,
  input  wire        sw_wr,
  input  wire        sw_rd,
  output reg  [15:0] sw_rdata,
  output reg         bb_wr,
  output reg         bb_rd,
  output reg  [7:0]  bb_addr,
  output reg  [15:0] bb_wdata,
  input  wire [15:0] bb_rdata
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [7:0] ST_IDLE  = 8'h01;
  localparam [7:0] ST_WRITE = 8'h02;
  localparam [7:0] ST_RDREQ = 8'h04;
  localparam [7:0] ST_RDCAP = 8'h08;
  localparam [7:0] ST_WAIT  = 8'h10;
  localparam [7:0] ST_RST2  = 8'h20;
  localparam [7:0] ST_HOLD  = 8'h40;
  localparam [7:0] ST_DONE  = 8'h80;

  reg [7:0]  state_ff;
  reg [7:0]  nxt_state;
  reg [3:0]  cmd_ff;
  reg [15:0] shadow_ff;
  reg [15:0] mask_ff;
  reg [15:0] pass_fail_ff;
  reg [15:0] ready_code_ff;
  reg [7:0]  word_addr_ff;
  reg [15:0] word_data_ff;
  reg [15:0] wait_bit_ff;
  reg        poll_ready_ff;
  reg [31:0] timer_ff;
  reg [31:0] period_ff;
  reg        busy_ff;
  reg        timeout_ff;
  reg        data_ready_ff;
  reg        retry_ff;
  reg [15:0] rd_sel;

  // Reserved bits are masked off every command-built word sent to the control word; CMD_WRITE_WORD data goes unmasked
  function [15:0] ctl_word;
    input [15:0] bits;
    begin
      ctl_word = bits & ~`CTL_RESERVED_MASK;
    end
  endfunction

  function [15:0] one_bit;
    input integer pos;
    begin
      one_bit = 16'h0001 << pos;
    end
  endfunction

  // ----------------------------------------------------------------
  // Software read port
  // ----------------------------------------------------------------
  always @* begin
    case (sw_addr)
      `HREG_COMMAND:        rd_sel = {12'h000, cmd_ff};
      `HREG_STATUS:         rd_sel = {11'h000, retry_ff, data_ready_ff, timeout_ff,
                                      poll_ready_ff, busy_ff};
      `HREG_CONTROL_SHADOW: rd_sel = shadow_ff;
      `HREG_MASK:           rd_sel = mask_ff;
      `HREG_PASS_FAIL:      rd_sel = pass_fail_ff;
      `HREG_WORD_ADDR:      rd_sel = {8'h00, word_addr_ff};
      `HREG_WORD_DATA:      rd_sel = word_data_ff;
      `HREG_READY_CODE:     rd_sel = ready_code_ff;
      default:              rd_sel = 16'h0000;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      sw_rdata <= 16'h0000;
    end else if (sw_rd) begin
      sw_rdata <= rd_sel;
    end else begin
      sw_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  wire cmd_take = sw_wr && (sw_addr == `HREG_COMMAND) && !busy_ff;

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:  if (cmd_take) nxt_state = ST_WRITE;
      ST_WRITE: nxt_state = ST_RDREQ;
      ST_RDREQ: nxt_state = ST_RDCAP;
      ST_RDCAP: nxt_state = ST_WAIT;
      ST_WAIT:  nxt_state = ST_WAIT;
      ST_RST2:  nxt_state = ST_DONE;
      ST_HOLD:  nxt_state = ST_HOLD;
      ST_DONE:  nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      state_ff      <= ST_IDLE;
      cmd_ff        <= `CMD_NONE;
      shadow_ff     <= 16'h0000;
      mask_ff       <= 16'h0000;
      pass_fail_ff  <= 16'h0000;
      ready_code_ff <= 16'h0000;
      word_addr_ff  <= 8'h00;
      word_data_ff  <= 16'h0000;
      wait_bit_ff   <= 16'h0000;
      poll_ready_ff <= 1'b0;
      timer_ff      <= 32'h0000_0000;
      period_ff     <= 32'h0000_0000;
      busy_ff       <= 1'b0;
      timeout_ff    <= 1'b0;
      data_ready_ff <= 1'b0;
      retry_ff      <= 1'b0;
      bb_wr         <= 1'b0;
      bb_rd         <= 1'b0;
      bb_addr       <= 8'h00;
      bb_wdata      <= 16'h0000;
    end else begin
      bb_wr <= 1'b0;
      bb_rd <= 1'b0;
      // Data is fresh only every period; pacing keeps polling noise down
      if (period_ff != 32'h0000_0000) begin
        period_ff <= period_ff - 32'h0000_0001;
      end else if (!busy_ff) begin
        period_ff     <= DATA_PERIOD_CYC[31:0];
        poll_ready_ff <= 1'b1;
      end
      if (sw_wr && !busy_ff) begin
        case (sw_addr)
          `HREG_MASK:      mask_ff      <= sw_wdata;
          `HREG_WORD_ADDR: word_addr_ff <= sw_wdata[7:0];
          `HREG_WORD_DATA: word_data_ff <= sw_wdata;
          default:         mask_ff      <= mask_ff;
        endcase
      end
      // Own writes keep the shadow fresh; a second-step write ends in board reset
      if (bb_wr && bb_addr == `OFS_BOARD_CONTROL_WORD && !bb_wdata[`BIT_RESET_SECOND]) begin
        shadow_ff <= bb_wdata;
      end
      state_ff <= nxt_state;
      case (state_ff)
        ST_IDLE: begin
          if (cmd_take) begin
            cmd_ff     <= sw_wdata[3:0];
            busy_ff    <= 1'b1;
            timeout_ff <= 1'b0;
            retry_ff   <= 1'b0;
            timer_ff   <= 32'h0000_0000;
          end else if (poll_ready_ff) begin
            // Periodic status sample of the control word
            poll_ready_ff <= 1'b0;
            bb_rd         <= 1'b1;
            bb_addr       <= `OFS_BOARD_CONTROL_WORD;
          end
          if (bb_rd) begin
            shadow_ff     <= bb_rdata;
            data_ready_ff <= bb_rdata[`BIT_DATA_READY];
          end
        end
        ST_WRITE: begin
          bb_wr   <= 1'b1;
          bb_addr <= `OFS_BOARD_CONTROL_WORD;
          case (cmd_ff)
            `CMD_SOFT_RESET: begin
              // First step: first bit one, second bit zero
              bb_wdata    <= ctl_word((shadow_ff | one_bit(`BIT_RESET_FIRST))
                                      & ~one_bit(`BIT_RESET_SECOND));
              wait_bit_ff <= one_bit(`BIT_RESET_FIRST);
            end
            `CMD_WATCHDOG_ACK: begin
              bb_wdata    <= ctl_word(shadow_ff | one_bit(`BIT_RESET_SECOND));
              wait_bit_ff <= one_bit(`BIT_WATCHDOG);
            end
            `CMD_APPLY_SETTINGS: begin
              bb_addr     <= `OFS_CHANNEL_SELECT_MASK;
              bb_wdata    <= mask_ff;
              wait_bit_ff <= one_bit(`BIT_APPLY_SETTINGS);
            end
            `CMD_CAL_START: begin
              bb_addr     <= `OFS_CHANNEL_SELECT_MASK;
              bb_wdata    <= mask_ff;
              wait_bit_ff <= one_bit(`BIT_CAL_START);
            end
            `CMD_CAL_FINISH: begin
              bb_wdata    <= ctl_word(shadow_ff | one_bit(`BIT_CAL_FINISH));
              wait_bit_ff <= one_bit(`BIT_CAL_FINISH);
            end
            `CMD_AUTOZERO: begin
              bb_wdata    <= ctl_word(shadow_ff | one_bit(`BIT_AUTOZERO));
              wait_bit_ff <= one_bit(`BIT_AUTOZERO);
            end
            `CMD_LOAD_CUSTOM: begin
              bb_wdata    <= ctl_word(shadow_ff | one_bit(`BIT_LOAD_CUSTOM));
              wait_bit_ff <= one_bit(`BIT_LOAD_CUSTOM);
            end
            `CMD_STORE_COEF: begin
              bb_wdata    <= ctl_word(shadow_ff | one_bit(`BIT_STORE_COEF));
              wait_bit_ff <= one_bit(`BIT_STORE_COEF);
            end
            `CMD_INDICATOR_ON: begin
              bb_wdata    <= ctl_word(shadow_ff | one_bit(`BIT_INDICATOR));
              wait_bit_ff <= 16'h0000;
            end
            `CMD_INDICATOR_OFF: begin
              bb_wdata    <= ctl_word(shadow_ff & ~one_bit(`BIT_INDICATOR));
              wait_bit_ff <= 16'h0000;
            end
            `CMD_TAKE_DATA: begin
              // Host clears data-ready once software has taken the data
              bb_wdata    <= ctl_word(shadow_ff & ~one_bit(`BIT_DATA_READY));
              wait_bit_ff <= 16'h0000;
            end
            `CMD_WRITE_WORD: begin
              // Software orders coefficient words MSW first at 0x80 or 0xc0
              bb_addr     <= word_addr_ff;
              bb_wdata    <= word_data_ff;
              wait_bit_ff <= 16'h0000;
            end
            default: begin
              bb_wr       <= 1'b0;
              wait_bit_ff <= 16'h0000;
            end
          endcase
          if (cmd_ff == `CMD_READ_WORD) begin
            bb_wr <= 1'b0;
          end
        end
        ST_RDREQ: begin
          // Second write for mask-first handshakes sets the control bit
          if (cmd_ff == `CMD_APPLY_SETTINGS || cmd_ff == `CMD_CAL_START) begin
            bb_wr    <= 1'b1;
            bb_addr  <= `OFS_BOARD_CONTROL_WORD;
            bb_wdata <= ctl_word(shadow_ff | wait_bit_ff);
          end else if (cmd_ff != `CMD_LOAD_CUSTOM) begin
            // Board owns its bus while it loads coefficients: no access then
            bb_rd   <= 1'b1;
            bb_addr <= (cmd_ff == `CMD_READ_WORD) ? word_addr_ff : `OFS_CHANNEL_PASS_FAIL;
          end
        end
        ST_RDCAP: begin
          if (cmd_ff == `CMD_READ_WORD) begin
            word_data_ff <= bb_rdata;
          end else if (!(cmd_ff == `CMD_APPLY_SETTINGS || cmd_ff == `CMD_CAL_START ||
                         cmd_ff == `CMD_LOAD_CUSTOM)) begin
            pass_fail_ff <= bb_rdata;
          end
          timer_ff <= 32'h0000_0000;
        end
        ST_WAIT: begin
          timer_ff <= timer_ff + 32'h0000_0001;
          if (wait_bit_ff == 16'h0000) begin
            state_ff <= ST_DONE;
          end else if (cmd_ff == `CMD_LOAD_CUSTOM && timer_ff < COEF_HOLD_CYC) begin
            state_ff <= ST_WAIT;
          end else if (timer_ff[3:0] == 4'h0 && !bb_rd) begin
            // While the board reconfigures the ready code is read, then the control word
            bb_rd   <= 1'b1;
            bb_addr <= (cmd_ff == `CMD_APPLY_SETTINGS) ? `OFS_READY_CODE
                                                       : `OFS_BOARD_CONTROL_WORD;
          end
          if (bb_rd && bb_addr == `OFS_READY_CODE) begin
            ready_code_ff <= bb_rdata;
            bb_rd         <= 1'b1;
            bb_addr       <= `OFS_BOARD_CONTROL_WORD;
          end else if (bb_rd) begin
            shadow_ff <= bb_rdata;
            // Board-cleared handshake bit ends the wait
            if ((bb_rdata & wait_bit_ff) == 16'h0000) begin
              state_ff <= (cmd_ff == `CMD_SOFT_RESET) ? ST_RST2 : ST_DONE;
            end
          end
          if (timer_ff >= RESET_WINDOW_CYC[31:0] && cmd_ff == `CMD_SOFT_RESET) begin
            // No second step after the window: sequence must be rerun
            timeout_ff <= 1'b1;
            retry_ff   <= 1'b1;
            state_ff   <= ST_DONE;
          end
        end
        ST_RST2: begin
          bb_wr    <= 1'b1;
          bb_addr  <= `OFS_BOARD_CONTROL_WORD;
          bb_wdata <= ctl_word((shadow_ff & ~one_bit(`BIT_RESET_FIRST))
                               | one_bit(`BIT_RESET_SECOND));
          // Board returns all control registers to reset values
          shadow_ff <= 16'h0000;
        end
        ST_HOLD: state_ff <= ST_DONE;
        ST_DONE: begin
          busy_ff <= 1'b0;
          if (cmd_ff == `CMD_APPLY_SETTINGS || cmd_ff == `CMD_CAL_START) begin
            mask_ff <= 16'h0000;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule

// ### hdl/board_ctl_map.vh
/*
  Register offsets, control word bit positions and timing counts of the
  acquisition board, as seen by the host-side sequencer.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef BOARD_CTL_MAP_VH
`define BOARD_CTL_MAP_VH

// ----------------------------------------------------------------
// Board register offsets (byte addresses on the board bus)
// ----------------------------------------------------------------
`define OFS_BOARD_CONTROL_WORD   8'h04
`define OFS_CHANNEL_SELECT_MASK  8'h06
`define OFS_CHANNEL_PASS_FAIL    8'h08
`define OFS_READY_CODE           8'h02
`define OFS_OFFSET_COEF_BASE     8'h80
`define OFS_GAIN_COEF_BASE       8'hc0

// ----------------------------------------------------------------
// Control word bit positions
// ----------------------------------------------------------------
`define BIT_INDICATOR            15
`define BIT_WATCHDOG             14
`define BIT_STORE_COEF           13
`define BIT_CUSTOM_ACTIVE        12
`define BIT_RESET_FIRST          8
`define BIT_RESET_SECOND         7
`define BIT_AUTOZERO             6
`define BIT_DATA_READY           5
`define BIT_LOAD_CUSTOM          4
`define BIT_APPLY_SETTINGS       3
`define BIT_CHAN_CALIBRATED      2
`define BIT_CAL_START            1
`define BIT_CAL_FINISH           0
`define CTL_RESERVED_MASK        16'h0e00

// ----------------------------------------------------------------
// Host-side register map (own port)
// ----------------------------------------------------------------
`define HREG_COMMAND             4'h0
`define HREG_STATUS              4'h1
`define HREG_CONTROL_SHADOW      4'h2
`define HREG_MASK                4'h3
`define HREG_PASS_FAIL           4'h4
`define HREG_WORD_ADDR           4'h5
`define HREG_WORD_DATA           4'h6
`define HREG_READY_CODE          4'h7

// Command codes written to the command register
`define CMD_NONE                 4'h0
`define CMD_SOFT_RESET           4'h1
`define CMD_WATCHDOG_ACK         4'h2
`define CMD_APPLY_SETTINGS       4'h3
`define CMD_CAL_START            4'h4
`define CMD_CAL_FINISH           4'h5
`define CMD_AUTOZERO             4'h6
`define CMD_LOAD_CUSTOM          4'h7
`define CMD_STORE_COEF           4'h8
`define CMD_INDICATOR_ON         4'h9
`define CMD_INDICATOR_OFF        4'ha
`define CMD_WRITE_WORD           4'hb
`define CMD_READ_WORD            4'hc
`define CMD_TAKE_DATA            4'hd

// ----------------------------------------------------------------
// Timing, clock 100 MHz
// ----------------------------------------------------------------
`define CLK_MHZ                  100
`define RESET_WINDOW_MS          2000
`define RESET_WINDOW_CYC         (`RESET_WINDOW_MS * 1000 * `CLK_MHZ)
`define DATA_PERIOD_MS           10
`define DATA_PERIOD_CYC          (`DATA_PERIOD_MS * 1000 * `CLK_MHZ)
`define COEF_HOLD_US             21
`define COEF_HOLD_CYC            (`COEF_HOLD_US * `CLK_MHZ)
`define POLL_GAP_CYC             16

`endif

// ### testbench/board_ctl_host_asserts.sv
/*
  Checker of the board bus and software port of board_ctl_host.
  Assumes one clock, mclk, and synchronous active-high srst.
*/
`timescale 1ns/1ps
module board_ctl_host_asserts #(
  parameter RESET_WINDOW_CYC = 200,
  parameter COEF_HOLD_CYC    = 30
) (
  input wire        mclk,
  input wire        srst,
  input wire        sw_rd,
  input wire [15:0] sw_rdata,
  input wire        bb_wr,
  input wire        bb_rd,
  input wire [7:0]  bb_addr,
  input wire [15:0] bb_wdata
);
  // ----
  // Helper state
  // ----
  localparam [15:0] HOLD_N = COEF_HOLD_CYC - 2;
  reg  [15:0] hold_ff;
  reg  [31:0] win_ff;
  reg         armed_ff;
  reg         mask_ff;
  wire        ctl_wr = bb_wr && bb_addr == 8'h04;
  always @(posedge mclk) begin
    if (srst) begin
      hold_ff  <= 16'h0;
      win_ff   <= 32'h0;
      armed_ff <= 1'h0;
      mask_ff  <= 1'h0;
    end else begin
      hold_ff  <= (ctl_wr && bb_wdata[4]) ? HOLD_N : hold_ff - (hold_ff != 16'h0);
      win_ff   <= (ctl_wr && bb_wdata[8]) ? 32'h0 : win_ff + 32'h1;
      armed_ff <= (ctl_wr && bb_wdata[8]) | (armed_ff & ~(ctl_wr & bb_wdata[7]));
      mask_ff  <= (bb_wr && bb_addr == 8'h06) | (mask_ff & ~(ctl_wr & bb_wdata[3]));
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // ----
  // Properties
  // ----
  chk_rdata_idle:
    assert property (!sw_rd |=> sw_rdata == 16'h0000) else $error("rdata outside answer");
  chk_strobe_excl:
    assert property (!(bb_wr && bb_rd)) else $error("board read and write together");
  chk_even_addr:
    assert property ((bb_wr || bb_rd) |-> !bb_addr[0]) else $error("odd board address");
  chk_reserved_zero:
    assert property (ctl_wr |-> (bb_wdata & 16'h0e00) == 16'h0) else $error("reserved set");
  chk_reset_steps:
    assert property (ctl_wr |-> !(bb_wdata[8] && bb_wdata[7])) else $error("both reset bits");
  chk_reset_window:
    assert property (ctl_wr && bb_wdata[7] && armed_ff |-> win_ff <= RESET_WINDOW_CYC + 32)
      else $error("second reset step too late");
  chk_coef_hold:
    assert property (hold_ff != 16'h0 |-> !bb_wr && !bb_rd) else $error("access in hold");
  chk_mask_first:
    assert property (ctl_wr && bb_wdata[3] |-> mask_ff) else $error("reconfigure before mask");
  chk_reconfig_quiet:
    assert property (ctl_wr && bb_wdata[3] |=>
      (!bb_wr && (!bb_rd || bb_addr == 8'h02 || bb_addr == 8'h04))[*8])
      else $error("access during reconfigure");
endmodule
bind board_ctl_host board_ctl_host_asserts #(
  .RESET_WINDOW_CYC(RESET_WINDOW_CYC),
  .COEF_HOLD_CYC   (COEF_HOLD_CYC)
) chk_u (
  .mclk    (mclk),
  .srst    (srst),
  .sw_rd   (sw_rd),
  .sw_rdata(sw_rdata),
  .bb_wr   (bb_wr),
  .bb_rd   (bb_rd),
  .bb_addr (bb_addr),
  .bb_wdata(bb_wdata)
);

// ### testbench/board_ctl_host_test.sv
/*
  Self-checking bench for board_ctl_host facing board_model.
  Assumes the checker is bound and the map header is on the include path.
*/
`timescale 1ns/1ps
`include "board_ctl_map.vh"
`define CHK(nm, exp, got) begin n_compared = n_compared + 1; \
  if ((got) !== (exp)) begin err_total = err_total + 1; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end
module board_ctl_host_test;
  // ----
  // Bench
  // ----
  reg         mclk, srst, sw_wr, sw_rd, watchdog_reset_flag_evt, keep_jumper;
  reg  [3:0]  sw_addr;
  reg  [15:0] sw_wdata, dly, rd;
  wire [15:0] sw_rdata, bb_wdata, bb_rdata;
  wire        bb_wr, bb_rd;
  wire [7:0]  bb_addr;
  integer     err_total = 0;
  integer     n_compared = 0;
  integer     cyc = 0;
  board_ctl_host #(
    .RESET_WINDOW_CYC(200),
    .DATA_PERIOD_CYC (100),
    .COEF_HOLD_CYC   (30)
  ) dut_u (.mclk(mclk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bb_wr(bb_wr), .bb_rd(bb_rd),
    .bb_addr(bb_addr), .bb_wdata(bb_wdata), .bb_rdata(bb_rdata));
  board_model bm (.mclk(mclk), .srst(srst), .bb_wr(bb_wr), .bb_rd(bb_rd),
    .bb_addr(bb_addr), .bb_wdata(bb_wdata), .bb_rdata(bb_rdata), .dly(dly),
    .watchdog_reset_flag_evt(watchdog_reset_flag_evt), .keep_jumper(keep_jumper));
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  task print_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin // Far beyond the slowest handshake chain
      err_total = err_total + 1;
      print_verdict;
    end
  end
  task sw_write(input [3:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'h1;
      @(posedge mclk);
      sw_wr <= 1'h0;
    end
  endtask
  task sw_read(input [3:0] a, output [15:0] d);
    begin
      @(posedge mclk);
      sw_addr <= a;
      sw_rd <= 1'h1;
      @(posedge mclk);
      sw_rd <= 1'h0;
      #1 d = sw_rdata;
    end
  endtask
  task wait_st(input [3:0] b, input v);
    integer i;
    begin
      sw_read(`HREG_STATUS, rd);
      for (i = 0; i < 3000 && rd[b] !== v; i = i + 1)
        sw_read(`HREG_STATUS, rd);
      `CHK("status", v, rd[b])
    end
  endtask
  task cmd(input [3:0] c);
    begin
      sw_write(`HREG_COMMAND, {12'h000, c});
      wait_st(4'h0, 1'h0);
    end
  endtask
  task word(input [15:0] a, input [15:0] d);
    begin
      sw_write(`HREG_WORD_ADDR, a);
      sw_write(`HREG_WORD_DATA, d);
      cmd(`CMD_WRITE_WORD);
    end
  endtask
  initial begin
    srst = 1'h1;
    sw_addr = 4'h0;
    sw_wdata = 16'h0;
    sw_wr = 1'h0;
    sw_rd = 1'h0;
    dly = 16'h0003;
    watchdog_reset_flag_evt = 1'h0;
    keep_jumper = 1'h0;
    repeat (8) @(posedge mclk);
    srst <= 1'h0;
    @(posedge mclk);
    #1 `CHK("reset regs", {16'h0, 16'h0012}, {bm.mask, bm.pf})
    cmd(`CMD_INDICATOR_ON);
    `CHK("led on", 1'h1, bm.ctrl[15])
    dly = 16'h0028;
    sw_write(`HREG_COMMAND, {12'h000, `CMD_AUTOZERO});
    sw_write(`HREG_COMMAND, {12'h000, `CMD_INDICATOR_OFF});
    wait_st(4'h0, 1'h0);
    `CHK("dropped", 2'h2, {bm.ctrl[15], bm.ctrl[6]})
    dly = 16'h0003;
    cmd(`CMD_INDICATOR_OFF);
    `CHK("led off", 1'h0, bm.ctrl[15])
    word(16'h0080, 16'h8001);
    word(16'h0082, 16'h0123);
    `CHK("coef", {16'h8001, 16'h0123}, {bm.coef[0], bm.coef[1]})
    sw_write(`HREG_WORD_ADDR, 16'h0008);
    cmd(`CMD_READ_WORD);
    sw_read(`HREG_WORD_DATA, rd);
    `CHK("pass fail", 16'h0012, rd)
    sw_write(4'hf, 16'hffff);
    sw_read(4'hf, rd);
    `CHK("unmapped", 16'h0, rd)
    cmd(`CMD_LOAD_CUSTOM);
    `CHK("load", 2'h1, {bm.ctrl[4], bm.ctrl[12]})
    cmd(`CMD_STORE_COEF);
    `CHK("store", 2'h0, {bm.ctrl[13], bm.ctrl[12]})
    sw_write(`HREG_MASK, 16'h0005);
    cmd(`CMD_APPLY_SETTINGS);
    `CHK("apply", {16'h0005, 17'h0}, {bm.seen_mask, bm.ctrl[3], bm.mask})
    sw_read(`HREG_MASK, rd);
    `CHK("mask", 16'h0, rd)
    sw_write(`HREG_MASK, 16'h8001);
    cmd(`CMD_CAL_START);
    `CHK("cal start", {16'h8001, 2'h1}, {bm.seen_mask, bm.ctrl[1], bm.ctrl[2]})
    cmd(`CMD_CAL_FINISH);
    `CHK("cal end", 2'h0, {bm.ctrl[0], bm.ctrl[2]})
    wait_st(4'h3, 1'h1);
    cmd(`CMD_TAKE_DATA);
    `CHK("taken", 1'h0, bm.ctrl[5])
    keep_jumper = 1'h1;
    cmd(`CMD_SOFT_RESET);
    `CHK("soft reset", {32'h1, 16'h8000}, {bm.resets, bm.ctrl & 16'hffdf})
    keep_jumper = 1'h0;
    @(posedge mclk);
    watchdog_reset_flag_evt <= 1'h1;
    @(posedge mclk);
    watchdog_reset_flag_evt <= 1'h0;
    #1 `CHK("watchdog_reset_flag", 1'h1, bm.ctrl[14])
    cmd(`CMD_WATCHDOG_ACK);
    `CHK("watchdog_reset_flag ack", {32'h2, 16'h0}, {bm.resets, bm.ctrl & 16'hffdf})
    dly = 16'h012c;
    cmd(`CMD_SOFT_RESET);
    sw_read(`HREG_STATUS, rd);
    `CHK("late", {32'h2, 1'h1}, {bm.resets, rd[4] | rd[2]})
    print_verdict;
  end
endmodule

// ### testbench/board_model.sv
/*
  Behavioural acquisition board: control word, mask, pass/fail, coefficients.
  Assumes a bus read answered within the bb_rd cycle; dly sets handshake speed.
*/
`timescale 1ns/1ps
module board_model #(
  parameter          WIN       = 200,
  parameter          PERIOD    = 1000,
  parameter [15:0]   PF_INIT   = 16'h0012,
  parameter [15:0]   BUSY_CODE = 16'h5a5a
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire        bb_wr,
  input  wire        bb_rd,
  input  wire [7:0]  bb_addr,
  input  wire [15:0] bb_wdata,
  output wire [15:0] bb_rdata,
  input  wire [15:0] dly,
  input  wire        watchdog_reset_flag_evt,
  input  wire        keep_jumper
);
  // ----
  // Board state
  // ----
  reg [15:0] ctrl, mask, pf, seen_mask;
  reg [15:0] ans, clr;
  // Answer stands while the strobe is high; an idle bus shows the inverse
  assign bb_rdata = bb_rd ? ans : ~ans;
  reg [15:0] coef [0:63];
  reg        armed;
  integer    tmr, win_cnt, per_cnt, resets;
  task full_reset;
    begin
      ctrl  = {keep_jumper, 15'h0};
      mask  = 16'h0;
      pf    = PF_INIT;
      armed = 1'h0;
    end
  endtask
  // State moves on the falling edge so the answer is settled at the sampling edge
  always @(negedge mclk) begin
    if (srst) begin
      full_reset;
      ans <= 16'h0;
      resets = 0;
      tmr = 0;
      win_cnt = 0;
      per_cnt = 0;
    end else begin
      clr = 16'h0;
      per_cnt = per_cnt + 1;
      win_cnt = win_cnt + 1;
      if (per_cnt >= PERIOD) begin
        per_cnt = 0;
        ctrl[5] = 1'h1;
      end
      if (watchdog_reset_flag_evt)
        ctrl[14] = 1'h1;
      if (tmr > 0) begin
        tmr = tmr - 1;
        if (tmr == 0) begin
          if (ctrl[4])
            ctrl[12] = 1'h1;
          if (ctrl[13])
            ctrl[12] = 1'h0;
          if (ctrl[1] | ctrl[0])
            ctrl[2] = ctrl[1];
          if (ctrl[3] | ctrl[1] | ctrl[0])
            mask = 16'h0;
          clr = ctrl & 16'h215b;
          ctrl = ctrl & ~16'h215b;
        end
      end
      if (bb_wr && bb_addr == 8'h06)
        mask = bb_wdata;
      if (bb_wr && bb_addr[7])
        coef[bb_addr[6:1]] = bb_wdata;
      if (bb_wr && bb_addr == 8'h04) begin
        if (bb_wdata[7] && (ctrl[14] || (armed && win_cnt <= WIN))) begin
          full_reset;
          resets = resets + 1;
        end else begin
          if (bb_wdata[8]) begin
            armed = 1'h1;
            win_cnt = 0;
          end
          if ((bb_wdata & 16'h000b) != 16'h0)
            seen_mask = mask;
          ctrl = ((bb_wdata & 16'hafdb) | (ctrl & 16'h5004) | (ctrl & bb_wdata & 16'h0020))
                 & ~clr;
          if ((bb_wdata & 16'h215b) != 16'h0)
            tmr = dly;
        end
      end
      case (bb_addr)
        8'h02: ans <= (tmr > 0 && ctrl[3]) ? BUSY_CODE : 16'h0;
        8'h04: ans <= ctrl;
        8'h06: ans <= mask;
        8'h08: ans <= pf;
        default: ans <= bb_addr[7] ? coef[bb_addr[6:1]] : 16'h0;
      endcase
    end
  end
endmodule
